// *** rtl/rmrf_framer.v ***
// Response and data receive framer that drives the module's UART side.
//
// Function
// - Every response and receive starts with the asterisk prefix.
// - Response name is the two characters of the causing command.
// - An equals sign follows the name, then the parameter bytes.
// - Every output ends with carriage return then line feed.
// - Received radio data goes out under the data receive name.
// - Ordinary responses carry one byte as two hex characters.
// - User identifier response carries four hex characters.
// - Signal strength response is two hex, comma, two hex.
// - Data receive carries a two hex count then that many raw bytes.
// - Channel report carries two hex per antenna, two antennas, 20 channels.
// - Serial number response carries exactly nine characters.
// - Output for command responses, far end results and data receives.
// - Exactly one response per command, after a processing delay.
// - Errored radio frames are dropped silently with no output.
// - Test packets are returned unchanged, sizes zero to maximum.
// - Signal strength answer reports the source station level.
// - Request to send is low while the buffer can accept data.
`include "rmrf_regs.vh"

module rmrf_framer (
  input  wire       clk,            // System clock, 25 MHz.
  input  wire       arst_n,         // Asynchronous reset, active low.
  input  wire       req_valid,      // Response request present.
  input  wire [2:0] req_kind,       // Parameter layout of the response.
  input  wire [7:0] req_name0,      // First name character.
  input  wire [7:0] req_name1,      // Second name character.
  input  wire [7:0] req_len,        // Byte count for variable responses.
  output reg        req_ready,      // Framer takes a request.
  output reg  [7:0] par_idx,        // Index of parameter byte wanted.
  input  wire [7:0] par_byte,       // Parameter byte at par_idx.
  input  wire       rx_byte_valid,  // Radio payload byte strobe.
  input  wire [7:0] rx_byte,        // Radio payload byte.
  input  wire       rx_frame_end,   // Radio frame finished strobe.
  input  wire       rx_frame_err,   // Finished frame had an error.
  input  wire       rx_is_test,     // Finished frame is a test packet.
  output reg        rts_n,          // Request to send, active low.
  input  wire       cts_n,          // Clear to send, active low.
  output reg  [7:0] tx_data,        // UART byte to send.
  output reg        tx_valid,       // UART byte present.
  input  wire       tx_ready,       // UART accepts the byte.
  output reg  [7:0] lb_data,        // Test packet byte back to radio.
  output reg        lb_valid,       // Test packet byte present.
  input  wire       lb_ready        // Radio accepts the byte.
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [10:0] ST_IDLE  = 11'h001;
  localparam [10:0] ST_DELAY = 11'h002;
  localparam [10:0] ST_HEAD  = 11'h004;
  localparam [10:0] ST_FETCH = 11'h008;
  localparam [10:0] ST_GRAB  = 11'h010;
  localparam [10:0] ST_HI    = 11'h020;
  localparam [10:0] ST_LO    = 11'h040;
  localparam [10:0] ST_SEP   = 11'h080;
  localparam [10:0] ST_RAW   = 11'h100;
  localparam [10:0] ST_DATA  = 11'h200;
  localparam [10:0] ST_TERM  = 11'h400;
  localparam integer PROC_FULL = `RMRF_PROC_CYC;
  localparam [7:0]  PROC_CYC = PROC_FULL[7:0];

  reg [10:0] state;
  reg [2:0]  kind;
  reg [7:0]  name0;
  reg [7:0]  name1;
  reg [7:0]  plen;
  reg [7:0]  pcnt;
  reg [7:0]  hold;
  reg [1:0]  hidx;
  reg [7:0]  dcnt;
  reg [7:0]  bidx;
  reg        is_rx;
  reg        in_loop;
  reg        lf_next;
  reg        rx_done;

  reg        pend;
  reg        pend_test;
  reg [7:0]  cnt;
  reg [7:0]  wcnt;
  reg        ovf;

  wire [7:0] buf_q;
  wire [7:0] asc_hi;
  wire [7:0] asc_lo;
  wire       buf_we;
  wire       can_tx;
  wire       can_lb;
  wire       raw_kind;
  wire       last_par;
  wire       last_dat;
  reg  [7:0] next_len;
  reg [10:0] next_adv;

  // ****************************************************************
  // Payload store and hex converters
  // ****************************************************************
  assign buf_we = rx_byte_valid && !pend && (wcnt != `RMRF_MAX_PAYLOAD);

  rmrf_buf u_buf (
    .clk   (clk),
    .we    (buf_we),
    .waddr (wcnt),
    .wdata (rx_byte),
    .raddr (bidx),
    .rdata (buf_q)
  );

  rmrf_hex u_hex_hi (
    .nib (hold[7:4]),
    .asc (asc_hi)
  );

  rmrf_hex u_hex_lo (
    .nib (hold[3:0]),
    .asc (asc_lo)
  );

  // ****************************************************************
  // Frame capture
  // ****************************************************************

  // Bytes are gathered until the frame ends; only a clean frame is kept.
  // While one frame waits for output, new radio bytes are not stored,
  // which is why request to send goes high in that time.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend      <= 1'b0;
      pend_test <= 1'b0;
      cnt       <= 8'h00;
      wcnt      <= 8'h00;
      ovf       <= 1'b0;
      rts_n     <= 1'b0;
    end
    else
    begin
      if (rx_done)
        pend <= 1'b0;
      else if (!pend && rx_frame_end)
      begin
        if (!rx_frame_err && !ovf)
        begin
          pend      <= 1'b1;
          pend_test <= rx_is_test;
          cnt       <= wcnt;
        end
      end
      if (!pend && rx_frame_end)
      begin
        wcnt <= 8'h00;
        ovf  <= 1'b0;
      end
      else if (rx_byte_valid && !pend)
      begin
        if (wcnt == `RMRF_MAX_PAYLOAD)
          ovf <= 1'b1;
        else
          wcnt <= wcnt + 8'h01;
      end
      rts_n <= pend || (wcnt == `RMRF_MAX_PAYLOAD);
    end
  end

  // ****************************************************************
  // Sequencing helpers
  // ****************************************************************
  assign can_tx   = (!tx_valid || tx_ready) && !cts_n;
  assign can_lb   = !lb_valid || lb_ready;
  assign raw_kind = (kind == `RMRF_K_SER9) || (kind == `RMRF_K_VAR);
  assign last_par = (pcnt == plen - 8'h01);
  assign last_dat = (bidx == cnt - 8'h01);

  // Parameter length in source bytes for each response kind.
  always @*
  begin
    case (req_kind)
      `RMRF_K_HEX2: next_len = `RMRF_LEN_HEX2;
      `RMRF_K_HEX4: next_len = `RMRF_LEN_HEX4;
      `RMRF_K_PAIR: next_len = `RMRF_LEN_PAIR;
      `RMRF_K_CHAN: next_len = `RMRF_LEN_CHAN;
      `RMRF_K_SER9: next_len = `RMRF_LEN_SER9;
      default:      next_len = req_len;
    endcase
  end

  // Where to go after a parameter character pair or raw byte is sent.
  always @*
  begin
    if (last_par)
      next_adv = (is_rx && (cnt != 8'h00)) ? ST_DATA : ST_TERM;
    else if ((kind == `RMRF_K_PAIR) && (state == ST_LO))
      next_adv = ST_SEP;
    else
      next_adv = ST_FETCH;
  end

  // ****************************************************************
  // Output sequencer
  // ****************************************************************

  // One output at a time; a command wins only when req_ready is already high, so a
  // frame already pending goes out before a command waiting behind another output.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state     <= ST_IDLE;
      kind      <= `RMRF_K_HEX2;
      name0     <= 8'h00;
      name1     <= 8'h00;
      plen      <= 8'h00;
      pcnt      <= 8'h00;
      hold      <= 8'h00;
      hidx      <= 2'h0;
      dcnt      <= 8'h00;
      bidx      <= 8'h00;
      is_rx     <= 1'b0;
      in_loop   <= 1'b0;
      lf_next   <= 1'b0;
      rx_done   <= 1'b0;
      req_ready <= 1'b0;
      par_idx   <= 8'h00;
      tx_data   <= 8'h00;
      tx_valid  <= 1'b0;
      lb_data   <= 8'h00;
      lb_valid  <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (tx_valid && tx_ready)
        tx_valid <= 1'b0;
      if (lb_valid && lb_ready)
        lb_valid <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          hidx <= 2'h0;
          // Keep the echo index while the radio side stalls mid-packet.
          if (!in_loop)
            bidx <= 8'h00;
          // A finished frame still reads as pending for one cycle, so
          // rx_done blocks a second copy of the same output.
          if (req_valid && req_ready)
          begin
            kind      <= req_kind;
            name0     <= req_name0;
            name1     <= req_name1;
            plen      <= next_len;
            is_rx     <= 1'b0;
            dcnt      <= 8'h00;
            req_ready <= 1'b0;
            state     <= ST_DELAY;
          end
          else if (pend && !pend_test && !rx_done)
          begin
            kind      <= `RMRF_K_HEX2;
            name0     <= `RMRF_RXTAG_C0;
            name1     <= `RMRF_RXTAG_C1;
            plen      <= `RMRF_LEN_HEX2;
            is_rx     <= 1'b1;
            req_ready <= 1'b0;
            state     <= ST_HEAD;
          end
          else if (pend && pend_test && !in_loop && !rx_done)
          begin
            in_loop   <= 1'b1;
            req_ready <= 1'b0;
          end
          else if (in_loop)
          begin
            // Test packet goes back to the radio byte for byte.
            if (cnt == 8'h00)
            begin
              in_loop <= 1'b0;
              rx_done <= 1'b1;
            end
            else if (can_lb)
            begin
              lb_data  <= buf_q;
              lb_valid <= 1'b1;
              bidx     <= bidx + 8'h01;
              if (last_dat)
              begin
                in_loop <= 1'b0;
                rx_done <= 1'b1;
              end
            end
          end
          else
            req_ready <= !rx_done;
        end
        ST_DELAY:
        begin
          // Processing delay before the single response is framed.
          dcnt <= dcnt + 8'h01;
          if (dcnt == PROC_CYC - 8'h01)
            state <= ST_HEAD;
        end
        ST_HEAD:
        begin
          if (can_tx)
          begin
            tx_valid <= 1'b1;
            hidx     <= hidx + 2'h1;
            case (hidx)
              2'h0:    tx_data <= `RMRF_PREFIX;
              2'h1:    tx_data <= name0;
              2'h2:    tx_data <= name1;
              default: tx_data <= `RMRF_EQUALS;
            endcase
            if (hidx == `RMRF_HEAD_LAST)
            begin
              pcnt  <= 8'h00;
              state <= (plen == 8'h00) ? ST_TERM : ST_FETCH;
            end
          end
        end
        ST_FETCH:
        begin
          par_idx <= pcnt;
          state   <= ST_GRAB;
        end
        ST_GRAB:
        begin
          // The count byte of a data receive comes from the stored frame;
          // signal strength levels come from the parameter source.
          hold  <= is_rx ? cnt : par_byte;
          state <= raw_kind ? ST_RAW : ST_HI;
        end
        ST_HI:
        begin
          if (can_tx)
          begin
            tx_data  <= asc_hi;
            tx_valid <= 1'b1;
            state    <= ST_LO;
          end
        end
        ST_LO, ST_RAW:
        begin
          if (can_tx)
          begin
            tx_data  <= (state == ST_RAW) ? hold : asc_lo;
            tx_valid <= 1'b1;
            pcnt     <= pcnt + 8'h01;
            state    <= next_adv;
          end
        end
        ST_SEP:
        begin
          if (can_tx)
          begin
            tx_data  <= `RMRF_COMMA;
            tx_valid <= 1'b1;
            state    <= ST_FETCH;
          end
        end
        ST_DATA:
        begin
          if (can_tx)
          begin
            tx_data  <= buf_q;
            tx_valid <= 1'b1;
            bidx     <= bidx + 8'h01;
            if (last_dat)
              state <= ST_TERM;
          end
        end
        ST_TERM:
        begin
          if (can_tx)
          begin
            tx_valid <= 1'b1;
            lf_next  <= !lf_next;
            tx_data  <= lf_next ? `RMRF_LF : `RMRF_CR;
            if (lf_next)
            begin
              rx_done <= is_rx;
              state   <= ST_IDLE;
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule // rmrf_framer

// *** shared/rmrf_regs.vh ***
// Constants shared by the response and receive framer files.
`ifndef RMRF_REGS_VH
`define RMRF_REGS_VH

// ****************************************************************
// Framing characters
// ****************************************************************
`define RMRF_PREFIX      8'h2a
`define RMRF_EQUALS      8'h3d
`define RMRF_COMMA       8'h2c
`define RMRF_CR          8'h0d
`define RMRF_LF          8'h0a
`define RMRF_RXTAG_C0    8'h44
`define RMRF_RXTAG_C1    8'h52

// ****************************************************************
// Response kinds and their parameter lengths in source bytes
// ****************************************************************
`define RMRF_K_HEX2      3'h0
`define RMRF_K_HEX4      3'h1
`define RMRF_K_PAIR      3'h2
`define RMRF_K_CHAN      3'h3
`define RMRF_K_SER9      3'h4
`define RMRF_K_VAR       3'h5
`define RMRF_LEN_HEX2    8'h01
`define RMRF_LEN_HEX4    8'h02
`define RMRF_LEN_PAIR    8'h02
`define RMRF_LEN_CHAN    8'h28
`define RMRF_LEN_SER9    8'h09
`define RMRF_MAX_PAYLOAD 8'hff
`define RMRF_HEAD_LAST   2'h3
`define RMRF_HEX_TEN     8'h0a
`define RMRF_HEX_DIGIT0  8'h30
`define RMRF_HEX_ALPHA   8'h37

// ****************************************************************
// Timing
// ****************************************************************
`define RMRF_CLK_NS        40
`define RMRF_PROC_DELAY_NS 2000
`define RMRF_PROC_CYC \
  ((`RMRF_PROC_DELAY_NS + `RMRF_CLK_NS - 1) / `RMRF_CLK_NS)

`endif

// *** rtl/rmrf_hex.v ***
// Nibble to upper case hexadecimal ASCII character converter.
`include "rmrf_regs.vh"

module rmrf_hex (
  input  wire [3:0] nib,  // Value to convert.
  output wire [7:0] asc   // ASCII digit or capital letter.
);

  wire [7:0] wide;

  // Digits below ten map to 0..9, the rest to A..F.
  assign wide = {4'h0, nib};
  assign asc  = (wide < `RMRF_HEX_TEN) ? (wide + `RMRF_HEX_DIGIT0)
                                       : (wide + `RMRF_HEX_ALPHA);

endmodule // rmrf_hex

// *** rtl/rmrf_buf.v ***
// Flip-flop payload store for one received radio frame.
`include "rmrf_regs.vh"

module rmrf_buf (
  input  wire       clk,    // System clock.
  input  wire       we,     // Write strobe.
  input  wire [7:0] waddr,  // Write index.
  input  wire [7:0] wdata,  // Write byte.
  input  wire [7:0] raddr,  // Read index.
  output wire [7:0] rdata   // Byte at the read index.
);

  wire [2047:0] flat;

  // One byte register per entry; contents need no reset.
  genvar i;
  generate
    for (i = 0; i < 256; i = i + 1)
    begin : ent
      reg [7:0] q;
      always @(posedge clk)
      begin
        if (we && ({24'h000000, waddr} == i))
          q <= wdata;
      end
      assign flat[i*8 +: 8] = q;
    end
  endgenerate

  assign rdata = flat[raddr*8 +: 8];

endmodule // rmrf_buf

// *** tb/rmrf_chk_sva.sv ***
// Port checker for the response and receive framer.
`include "rmrf_regs.vh"

module rmrf_chk (
  input wire logic       clk,          // System clock.
  input wire logic       arst_n,       // Reset, active low.
  input wire logic       req_valid,    // Request present.
  input wire logic [7:0] req_name0,    // First name char.
  input wire logic       req_ready,    // Request taken.
  input wire logic       rx_frame_end, // Frame end strobe.
  input wire logic       rx_frame_err, // Frame errored.
  input wire logic       rx_is_test,   // Test packet.
  input wire logic       rts_n,        // Request to send.
  input wire logic       cts_n,        // Clear to send.
  input wire logic [7:0] tx_data,      // UART byte.
  input wire logic       tx_valid,     // UART byte valid.
  input wire logic       tx_ready,     // UART ready.
  input wire logic [7:0] lb_data,      // Echo byte.
  input wire logic       lb_valid,     // Echo valid.
  input wire logic       lb_ready      // Echo ready.
);
  timeunit 1ns;
  timeprecision 1ps;
  wire        fire = tx_valid && tx_ready;
  wire        take = req_valid && req_ready;
  logic [8:0] pos;
  logic [7:0] last;
  logic [7:0] nm0;
  logic [7:0] wcnt;
  logic       resp;

  // Track the byte position within a frame; CR LF closes it.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pos <= 9'h000;
      last <= 8'h00;
      nm0 <= 8'h00;
      wcnt <= 8'h00;
      resp <= 1'b0;
    end
    else
    begin
      if (fire)
        last <= tx_data;
      if (fire && tx_data == `RMRF_LF && last == `RMRF_CR)
      begin
        pos <= 9'h000;
        resp <= 1'b0;
      end
      else if (fire)
        pos <= pos + 9'h001;
      // Saturate so a long wait never wraps back under the delay.
      if (take)
        wcnt <= 8'h00;
      else if (wcnt != 8'hff)
        wcnt <= wcnt + 8'h01;
      if (take)
      begin
        nm0 <= req_name0;
        resp <= 1'b1;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_prefix;
    fire && pos == 9'h000 |-> tx_data == `RMRF_PREFIX;
  endproperty
  a_prefix: assert property (p_prefix) else $error("bad prefix");
  property p_name;
    fire && pos == 9'h001 |-> tx_data == (resp ? nm0 : `RMRF_RXTAG_C0);
  endproperty
  a_name: assert property (p_name) else $error("bad name");
  property p_equals;
    fire && pos == 9'h003 |-> tx_data == `RMRF_EQUALS;
  endproperty
  a_equals: assert property (p_equals) else $error("bad equals");
  property p_crlf;
    fire && tx_data == `RMRF_LF |-> last == `RMRF_CR && pos > 9'h004;
  endproperty
  a_crlf: assert property (p_crlf) else $error("bad terminator");
  property p_delay;
    tx_valid && pos == 9'h000 && resp |-> wcnt >= `RMRF_PROC_CYC;
  endproperty
  a_delay: assert property (p_delay) else $error("answer too early");
  property p_single;
    take |=> (!req_ready) [*8];
  endproperty
  a_single: assert property (p_single) else $error("second take");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("tx byte dropped");
  property p_cts;
    cts_n [*2] ##0 !tx_valid |=> !tx_valid;
  endproperty
  a_cts: assert property (p_cts) else $error("output while stopped");
  property p_drop;
    rx_frame_end && rx_frame_err && !resp && !tx_valid |=> (!tx_valid) [*8];
  endproperty
  a_drop: assert property (p_drop) else $error("errored frame sent");
  property p_rts;
    rx_frame_end && !rx_frame_err && !rx_is_test |-> ##[1:3] rts_n;
  endproperty
  a_rts: assert property (p_rts) else $error("rts low while held");
  property p_lb;
    lb_valid && !lb_ready |=> lb_valid && $stable(lb_data);
  endproperty
  a_lb: assert property (p_lb) else $error("echo byte dropped");

  c_take: cover property (take);
  c_rx: cover property (fire && pos == 9'h001 && tx_data == `RMRF_RXTAG_C0);
  c_lb: cover property (lb_valid && lb_ready);
endmodule // rmrf_chk

bind rmrf_framer rmrf_chk i_rmrf_chk (.clk, .arst_n, .req_valid, .req_name0,
  .req_ready, .rx_frame_end, .rx_frame_err, .rx_is_test, .rts_n, .cts_n,
  .tx_data, .tx_valid, .tx_ready, .lb_data, .lb_valid, .lb_ready);

// *** tb/rmrf_host.sv ***
// Host controller model: UART sink with clear to send control.
module rmrf_host (
  input  wire logic       clk,      // System clock.
  input  wire logic       arst_n,   // Reset, active low.
  input  wire logic       slow,     // Stall at random when high.
  input  wire logic [7:0] tx_data,  // Byte from framer.
  input  wire logic       tx_valid, // Byte present.
  output logic            tx_ready, // Host takes the byte.
  output logic            cts_n     // Clear to send, active low.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rxq[$];
  integer     seed = 32'hcad5accb;

  initial
  begin
    tx_ready = 1'b1;
    cts_n = 1'b0;
  end

  // Bytes are queued and parsed later one at a time, frame by frame.
  always @(posedge clk)
  begin
    if (arst_n && tx_valid && tx_ready)
      rxq.push_back(tx_data);
    #1;
    tx_ready = !slow || ($random(seed) & 3) != 0;
    cts_n = slow && ($random(seed) & 7) == 0;
  end
endmodule // rmrf_host

// *** tb/radio_module_response_framing_bench.sv ***
// Self-checking bench for the response and receive framer.
`include "rmrf_regs.vh"

module radio_module_response_framing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, arst_n, req_valid, rx_byte_valid, rx_frame_end;
  logic       rx_frame_err, rx_is_test, lb_ready, slow, raw;
  logic [2:0] req_kind;
  logic [7:0] req_name0, req_name1, req_len, rx_byte, salt;
  wire        req_ready, rts_n, cts_n, tx_valid, tx_ready, lb_valid;
  wire  [7:0] par_idx, par_byte, tx_data, lb_data;
  logic [7:0] expq[$], lbx[$], lbq[$];
  integer     seed = 32'hcad5accb;
  integer     mismatches = 0, checks_done = 0, cyc = 0;

  // Parameter bytes; raw kinds keep bit 7 set so no CR or LF can occur.
  function automatic logic [7:0] pb(input logic [7:0] i);
    return raw ? (8'h80 | (i ^ salt)) : (i ^ salt);
  endfunction
  assign par_byte = raw ? (8'h80 | (par_idx ^ salt)) : (par_idx ^ salt);

  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction

  rmrf_framer i_rmrf_framer (.clk, .arst_n, .req_valid, .req_kind,
    .req_name0, .req_name1, .req_len, .req_ready, .par_idx, .par_byte,
    .rx_byte_valid, .rx_byte, .rx_frame_end, .rx_frame_err, .rx_is_test,
    .rts_n, .cts_n, .tx_data, .tx_valid, .tx_ready, .lb_data, .lb_valid,
    .lb_ready);
  rmrf_host i_rmrf_host (.clk, .arst_n, .slow, .tx_data, .tx_valid,
    .tx_ready, .cts_n);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Echo collector; the radio side stalls at random.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      mismatches++;
      print_verdict;
    end
    if (lb_valid && lb_ready)
      lbq.push_back(lb_data);
    #1 lb_ready = $random(seed) & 1;
  end

  task print_verdict;
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t saw %h wanted %h", $time, got, exp);
    end
  endtask

  task automatic push_hex(input logic [7:0] b);
    expq.push_back(hx(b[7:4]));
    expq.push_back(hx(b[3:0]));
  endtask

  // Waits for the expected bytes, lets stray ones show, then compares.
  task automatic drain;
    int n;
    n = 0;
    while ((i_rmrf_host.rxq.size() < expq.size() ||
            lbq.size() < lbx.size()) && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (80) @(posedge clk);
    #1;
    check(16'(i_rmrf_host.rxq.size()), 16'(expq.size()));
    foreach (expq[i]) check(i_rmrf_host.rxq[i], expq[i]);
    check(16'(lbq.size()), 16'(lbx.size()));
    foreach (lbx[i]) check(lbq[i], lbx[i]);
    i_rmrf_host.rxq.delete();
    expq.delete();
    lbq.delete();
    lbx.delete();
  endtask

  task automatic do_req(input logic [2:0] k, input logic [7:0] len);
    int n;
    salt = $random(seed);
    raw = (k >= `RMRF_K_SER9);
    req_kind = k;
    req_len = len;
    req_name0 = 8'h41 + ($random(seed) & 15);
    req_name1 = 8'h41 + ($random(seed) & 15);
    req_valid = 1'b1;
    expq = '{`RMRF_PREFIX, req_name0, req_name1, `RMRF_EQUALS};
    if (k < 3)
      push_hex(pb(8'h00));
    if (k == 2)
      expq.push_back(`RMRF_COMMA);
    if (k == 1 || k == 2)
      push_hex(pb(8'h01));
    for (n = 0; k == 3 && n < 40; n++)
      push_hex(pb(n[7:0]));
    for (n = 0; k >= 4 && n < (k == 4 ? 9 : len); n++)
      expq.push_back(pb(n[7:0]));
    expq.push_back(`RMRF_CR);
    expq.push_back(`RMRF_LF);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 200);
    #1 req_valid = 1'b0;
    drain;
  endtask

  // Sends a radio frame, byte by byte, only while rts_n is low.
  task automatic rx_frame(input int len, input logic err, input logic tst);
    int n, w;
    if (!err && !tst)
    begin
      expq = '{`RMRF_PREFIX, `RMRF_RXTAG_C0, `RMRF_RXTAG_C1, `RMRF_EQUALS};
      push_hex(len[7:0]);
    end
    n = 0;
    w = 0;
    while (n < len && w < 3000)
    begin
      rx_byte_valid = (rts_n === 1'b0);
      rx_byte = 8'h80 | $random(seed);
      if (rx_byte_valid && tst)
        lbx.push_back(rx_byte);
      else if (rx_byte_valid && !err)
        expq.push_back(rx_byte);
      n += rx_byte_valid;
      @(posedge clk);
      #1 w++;
    end
    rx_byte_valid = 1'b0;
    if (!err && !tst)
    begin
      expq.push_back(`RMRF_CR);
      expq.push_back(`RMRF_LF);
    end
    rx_frame_err = err;
    rx_is_test = tst;
    rx_frame_end = 1'b1;
    @(posedge clk);
    #1 rx_frame_end = 1'b0;
    drain;
  endtask

  initial
  begin
    {arst_n, req_valid, rx_byte_valid, rx_frame_end, rx_frame_err} = 5'h00;
    {rx_is_test, slow, raw, lb_ready} = 4'h1;
    {req_kind, req_name0, req_name1, req_len, rx_byte, salt} = 43'h0;
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    // Prompt host first, then a host that stalls and stops output.
    for (int s = 0; s < 2; s++)
    begin
      slow = s[0];
      do_req(`RMRF_K_HEX2, 8'h00);
      do_req(`RMRF_K_HEX4, 8'h00);
      do_req(`RMRF_K_PAIR, 8'h00);
      do_req(`RMRF_K_CHAN, 8'h00);
      do_req(`RMRF_K_SER9, 8'h00);
      do_req(`RMRF_K_VAR, s ? 8'hff : 8'h00);
      rx_frame(s ? 255 : 0, 1'b0, 1'b0);
      rx_frame($random(seed) & 63, 1'b1, 1'b0);
      rx_frame(s ? 255 : 0, 1'b0, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
        do_req(3'($unsigned($random(seed)) % 6), $random(seed));
        rx_frame($random(seed) & 31, 1'b0, i[0]);
      end
    end
    print_verdict;
  end
endmodule // radio_module_response_framing_bench
